// [rtl/lar_params.svh]
`ifndef LAR_PARAMS_SVH
`define LAR_PARAMS_SVH

// Register addresses on the control port
`define LAR_ADDR_LINE2_LEFT 7'h14
`define LAR_ADDR_RLINE1_LEFT 7'h15

// Field positions
`define LAR_MODE_BIT 7
`define LAR_LVL_MSB 6
`define LAR_LVL_LSB 3
`define LAR_BIAS_BIT 2

// Reset values and special codes
`define LAR_MODE_RST 1'b0
`define LAR_LVL_RST 4'hf
`define LAR_BIAS_RST 1'b0
`define LAR_LVL_DISCONNECT 4'hf
`define LAR_RDATA_UNMAPPED 8'h00

`endif

// [rtl/lar_pkg.sv]
package lar_pkg;

  // Control port request, one access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } lar_req_t;

  // Route settings toward the left mixer
  typedef struct packed {
    logic diff_mode;
    logic [3:0] level;
    logic connected;
  } lar_route_t;

endpackage

// [rtl/lar_route_reg.sv]
`timescale 1ns/1ns
`default_nettype none
`include "lar_params.svh"

module lar_route_reg #(
  parameter bit HAS_BIAS = 1'b1
) (
  // Clock, reset and enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [7:0] wdata_in,
  // Settings and readback
  output var lar_pkg::lar_route_t cfg_out,
  output logic bias_out,
  output logic [7:0] rdata_out
);
  import lar_pkg::*;

  logic mode_ff;
  logic [3:0] level_ff;
  logic conn_ff;
  logic bias_ff;
  logic [3:0] nxt_level;

  assign nxt_level = wdata_in[`LAR_LVL_MSB:`LAR_LVL_LSB];

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_ff <= `LAR_MODE_RST; // [R1] [R8]
    end else if (ce_in && wr_en_in) begin
      mode_ff <= wdata_in[`LAR_MODE_BIT]; // [R1] [R8]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      level_ff <= `LAR_LVL_RST; // [R3] [R10]
      conn_ff <= 1'b0;
    end else if (ce_in && wr_en_in) begin
      level_ff <= nxt_level; // [R3] [R10]
      // Any code but the disconnect code attaches the input to the mixer
      conn_ff <= (nxt_level != `LAR_LVL_DISCONNECT); // [R4]
    end
  end

  // Without a bias field the bit stays reserved and reads zero
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bias_ff <= `LAR_BIAS_RST; // [R6]
    end else if (ce_in && wr_en_in && HAS_BIAS) begin
      bias_ff <= wdata_in[`LAR_BIAS_BIT]; // [R6]
    end
  end

  assign cfg_out = '{diff_mode: mode_ff, level: level_ff, connected: conn_ff};
  assign bias_out = bias_ff;
  // Reserved low bits are not stored, so they always read zero
  assign rdata_out = {mode_ff, level_ff, bias_ff, 2'b00}; // [R7] [R11]

endmodule
`default_nettype wire

// [rtl/lar_regs.sv]
//Contract
// (R1) Line-two mode bit: single-ended or differential
// (R2) Host keeps both line-two routes same mode
// (R3) Line-two level code, reset disconnect 1111
// (R4) Non-disconnect level code connects the input
// (R5) Host never writes reserved codes 1001-1110
// (R6) Bias bit weakly biases unselected inputs
// (R7) Reserved low bits read zero, host writes zeros
// (R8) Right-line-one mode bit, resets single-ended
// (R9) Host keeps right-line-one mode same everywhere
// (R10) Right-line-one level code, reset disconnect 1111
// (R11) Reads return last written fields, zeros reserved
`timescale 1ns/1ns
`default_nettype none
`include "lar_params.svh"

module lar_regs (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Control port from the bus front end
  input wire lar_pkg::lar_req_t req_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Analog mixer controls
  output var lar_pkg::lar_route_t line2_left_cfg_out,
  output var lar_pkg::lar_route_t rline1_left_cfg_out,
  output logic cm_bias_en_out
);
  import lar_pkg::*;

  logic sel_line2;
  logic sel_rline1;
  logic [7:0] line2_rdata;
  logic [7:0] rline1_rdata;
  logic [7:0] nxt_rd_data;
  logic [7:0] rd_byte_ff;
  logic rd_valid_ff;

  // Address decode
  always_comb begin
    sel_line2 = 1'b0;
    sel_rline1 = 1'b0;
    if (req_in.addr == `LAR_ADDR_LINE2_LEFT) begin
      sel_line2 = 1'b1;
    end else if (req_in.addr == `LAR_ADDR_RLINE1_LEFT) begin
      sel_rline1 = 1'b1;
    end
  end

  lar_route_reg #(
    .HAS_BIAS(1'b1)
  ) u_line2_left (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .wr_en_in(req_in.wr && sel_line2),
    .wdata_in(req_in.wdata),
    .cfg_out(line2_left_cfg_out),
    .bias_out(cm_bias_en_out),
    .rdata_out(line2_rdata)
  );

  // This register has no bias field; bits 2-0 stay reserved
  lar_route_reg #(
    .HAS_BIAS(1'b0)
  ) u_rline1_left (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .wr_en_in(req_in.wr && sel_rline1),
    .wdata_in(req_in.wdata),
    .cfg_out(rline1_left_cfg_out),
    .bias_out(),
    .rdata_out(rline1_rdata)
  );

  // Read mux; a read in the same cycle as a write sees the old value
  always_comb begin
    if (sel_line2) begin
      nxt_rd_data = line2_rdata; // [R11]
    end else if (sel_rline1) begin
      nxt_rd_data = rline1_rdata; // [R11]
    end else begin
      nxt_rd_data = `LAR_RDATA_UNMAPPED;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_byte_ff <= 8'h00;
    end else if (ce_in && req_in.rd) begin
      rd_byte_ff <= nxt_rd_data; // [R7] [R11]
    end
  end

  // Valid holds while enable is low, so a stalled result is not lost
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_valid_ff <= 1'b0;
    end else if (ce_in) begin
      rd_valid_ff <= req_in.rd;
    end
  end

  assign rd_data_out = rd_byte_ff;
  assign rd_valid_out = rd_valid_ff;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_wr_line2;
    ce_in && req_in.wr && (req_in.addr == `LAR_ADDR_LINE2_LEFT);
  endsequence

  sequence s_wr_rline1;
    ce_in && req_in.wr && (req_in.addr == `LAR_ADDR_RLINE1_LEFT);
  endsequence

  sequence s_rd_line2_quiet;
    ce_in && req_in.rd && !req_in.wr && (req_in.addr == `LAR_ADDR_LINE2_LEFT);
  endsequence

  sequence s_rd_line2;
    ce_in && req_in.rd && (req_in.addr == `LAR_ADDR_LINE2_LEFT);
  endsequence

  sequence s_rd_rline1;
    ce_in && req_in.rd && (req_in.addr == `LAR_ADDR_RLINE1_LEFT);
  endsequence

  sequence s_rd_unmapped;
    ce_in && req_in.rd && !sel_line2 && !sel_rline1;
  endsequence

  sequence s_frozen;
    !ce_in;
  endsequence

  property p_mode_line2;
    s_wr_line2 |=> (line2_left_cfg_out.diff_mode == $past(req_in.wdata[7]));
  endproperty
  a_mode_line2: assert property (p_mode_line2) else $error("line2 mode not stored"); // [R1]

  property p_level_line2;
    s_wr_line2 |=> (line2_left_cfg_out.level == $past(req_in.wdata[6:3]));
  endproperty
  a_level_line2: assert property (p_level_line2) else $error("line2 level wrong"); // [R3]

  property p_reset_level;
    $fell(rst_in) |-> (line2_left_cfg_out.level == 4'hf) &&
      (rline1_left_cfg_out.level == 4'hf) && !line2_left_cfg_out.connected;
  endproperty
  a_reset_level: assert property (@(posedge ref_clk_in) p_reset_level)
    else $error("level reset not disconnect"); // [R3]

  property p_reset_mode;
    $fell(rst_in) |-> !line2_left_cfg_out.diff_mode && !rline1_left_cfg_out.diff_mode &&
      !cm_bias_en_out && !rd_valid_out;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode or bias reset wrong"); // [R1] [R8]

  property p_connect;
    (s_wr_line2 or s_wr_rline1) |=>
      ((line2_left_cfg_out.connected == (line2_left_cfg_out.level != 4'hf)) &&
       (rline1_left_cfg_out.connected == (rline1_left_cfg_out.level != 4'hf)));
  endproperty
  a_connect: assert property (p_connect) else $error("connect flag mismatch"); // [R4]

  property p_bias;
    s_wr_line2 |=> (cm_bias_en_out == $past(req_in.wdata[2]));
  endproperty
  a_bias: assert property (p_bias) else $error("bias bit not stored"); // [R6]

  // The second route shares the bit position but must never touch the bias
  property p_bias_keep;
    s_wr_rline1 |=> $stable(cm_bias_en_out);
  endproperty
  a_bias_keep: assert property (p_bias_keep) else $error("bias moved by other route"); // [R6]

  property p_resv_zero;
    s_rd_rline1 |=> (rd_valid_out && (rd_data_out[2:0] == 3'b000));
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits nonzero"); // [R7]

  property p_resv_line2;
    s_rd_line2 |=> (rd_valid_out && (rd_data_out[1:0] == 2'b00));
  endproperty
  a_resv_line2: assert property (p_resv_line2) else $error("line2 reserved nonzero"); // [R7]

  property p_mode_rline1;
    s_wr_rline1 |=> (rline1_left_cfg_out.diff_mode == $past(req_in.wdata[7]));
  endproperty
  a_mode_rline1: assert property (p_mode_rline1) else $error("rline1 mode wrong"); // [R8]

  property p_level_rline1;
    s_wr_rline1 ##1 (!ce_in || !req_in.wr || !sel_rline1)[*2] |->
      (rline1_left_cfg_out.level == $past(req_in.wdata[6:3], 2));
  endproperty
  a_level_rline1: assert property (p_level_rline1) else $error("rline1 level lost"); // [R10]

  property p_readback;
    s_wr_line2 ##1 s_rd_line2_quiet |=>
      (rd_data_out == {$past(req_in.wdata[7:2], 2), 2'b00});
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch"); // [R11]

  property p_line2_keep;
    s_wr_rline1 |=> $stable(line2_left_cfg_out);
  endproperty
  a_line2_keep: assert property (p_line2_keep) else $error("line2 moved by other write"); // [R11]

  property p_rline1_keep;
    s_wr_line2 |=> $stable(rline1_left_cfg_out);
  endproperty
  a_rline1_keep: assert property (p_rline1_keep) else $error("rline1 moved by other write"); // [R11]

  // Enable low must hold every register, a pending read result included
  property p_freeze;
    s_frozen |=> $stable(line2_left_cfg_out) && $stable(rline1_left_cfg_out) &&
      $stable(cm_bias_en_out) && $stable(rd_data_out) && $stable(rd_valid_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low"); // [R11]

  property p_unmapped;
    s_rd_unmapped |=> (rd_valid_out && (rd_data_out == `LAR_RDATA_UNMAPPED));
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_rd_valid_drop;
    (ce_in && !req_in.rd) |=> !rd_valid_out;
  endproperty
  a_rd_valid_drop: assert property (p_rd_valid_drop) else $error("read valid without read");

endmodule
`default_nettype wire

// [verif/lar_host.sv]
`timescale 1ns/1ns
`default_nettype none
module lar_host (
  // Control port toward the register block
  input wire logic ref_clk_in,
  output var lar_pkg::lar_req_t req_out
);
  import lar_pkg::*;
  // Mode bits the host also programs into the right-channel routes
  logic right_mode_line2 = 1'b0;
  logic right_mode_rline1 = 1'b0;
  initial req_out = '0;
  // Host duties applied to every compliant write
  function automatic logic [7:0] legal(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (v[6:3] inside {[4'h9:4'he]}) v[6:3] = 4'hf;
    v = v & ((a == 7'h15) ? 8'hf8 : 8'hfc);
    return v;
  endfunction
  // Both routes of one input get the same wiring mode
  task automatic mirror(input logic [6:0] a, input logic [7:0] v);
    if (a == 7'h14) right_mode_line2 = v[7];
    if (a == 7'h15) right_mode_rline1 = v[7];
  endtask
  // Write, then read back in the very next cycle
  task automatic write_read(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = legal(a, d);
    mirror(a, v);
    @(posedge ref_clk_in);
    #1;
    req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge ref_clk_in);
    #1;
    req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_in);
    #1;
    req_out = '0;
  endtask
  // Raw mode lets the bench break the write-zero duty on purpose
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        input logic raw);
    logic [7:0] v;
    v = raw ? d : legal(a, d);
    if (wr && !raw) mirror(a, v);
    @(posedge ref_clk_in);
    #1;
    req_out = '{wr: wr, rd: !wr, addr: a, wdata: v};
    @(posedge ref_clk_in);
    #1;
    req_out = '0;
  endtask
endmodule
`default_nettype wire

// [verif/left_adc_line_input_routing_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module left_adc_line_input_routing_regs_tb;
  import lar_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  lar_req_t req;
  logic [7:0] rd_data;
  logic rd_valid;
  lar_route_t cfg2;
  lar_route_t cfg1;
  logic bias;
  logic [7:0] expq[$];
  logic [7:0] d2;
  logic [7:0] d1;
  logic [3:0] lvl;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 4781;
  int r;
  always #2 ref_clk_in = ~ref_clk_in;
  lar_host host (.ref_clk_in(ref_clk_in), .req_out(req));
  lar_regs uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .line2_left_cfg_out(cfg2),
    .rline1_left_cfg_out(cfg1), .cm_bias_en_out(bias));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] ecfg(input logic [7:0] d);
    return {2'h0, d[7], d[6:3], d[6:3] != 4'hf};
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic raw);
    host.access(1'b1, a, d, raw);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.access(1'b0, a, 8'h00, 1'b0);
  endtask
  // Read results are matched in request order
  always @(posedge ref_clk_in) begin
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) chk("read count", 8'h00, 8'h01);
      else chk("read data", expq.pop_front(), rd_data);
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    chk("line2 cfg", 8'h1e, {2'h0, cfg2});
    chk("rline1 cfg", 8'h1e, {2'h0, cfg1});
    chk("bias", 8'h00, {7'h0, bias});
    rd(7'h14, 8'h78);
    rd(7'h15, 8'h78);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      lvl = (i < 9) ? i[3:0] : 4'hf;
      r = $random(seed);
      d2 = {r[0], lvl, r[1], 2'h0};
      d1 = {r[2], lvl, 3'h0};
      wr(7'h14, d2, 1'b0);
      chk("line2 cfg", ecfg(d2), {2'h0, cfg2});
      chk("bias", {7'h0, r[1]}, {7'h0, bias});
      chk("line2 mode", {7'h0, host.right_mode_line2}, {7'h0, cfg2.diff_mode});
      wr(7'h15, d1, 1'b0);
      chk("rline1 cfg", ecfg(d1), {2'h0, cfg1});
      chk("rline1 mode", {7'h0, host.right_mode_rline1}, {7'h0, cfg1.diff_mode});
      chk("line2 cfg", ecfg(d2), {2'h0, cfg2});
      rd(7'h14, d2);
      rd(7'h15, d1);
    end
    $display("test level codes done");
    expq.push_back(8'hb4);
    host.write_read(7'h14, 8'hb4);
    chk("line2 cfg", ecfg(8'hb4), {2'h0, cfg2});
    chk("bias", 8'h01, {7'h0, bias});
    expq.push_back(8'h28);
    host.write_read(7'h15, 8'h28);
    chk("rline1 cfg", ecfg(8'h28), {2'h0, cfg1});
    $display("test write then read done");
    wr(7'h14, 8'hff, 1'b1);
    wr(7'h15, 8'h07, 1'b1);
    chk("rline1 cfg", 8'h01, {2'h0, cfg1});
    rd(7'h14, 8'hfc);
    rd(7'h15, 8'h00);
    wr(7'h16, 8'h80, 1'b0);
    rd(7'h16, 8'h00);
    rd(7'h14, 8'hfc);
    $display("test reserved and unmapped done");
    // Let the last read result go before freezing, as valid holds while frozen
    @(posedge ref_clk_in);
    #1;
    ce_in = 1'b0;
    wr(7'h14, 8'h00, 1'b0);
    ce_in = 1'b1;
    chk("line2 cfg", 8'h3e, {2'h0, cfg2});
    rd(7'h14, 8'hfc);
    $display("test clock enable done");
    @(posedge ref_clk_in);
    #1;
    rst_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    chk("line2 cfg", 8'h1e, {2'h0, cfg2});
    chk("rline1 cfg", 8'h1e, {2'h0, cfg1});
    chk("bias", 8'h00, {7'h0, bias});
    rd(7'h15, 8'h78);
    $display("test mid-run reset done");
    for (int k = 0; k < 20 && expq.size() > 0; k++) @(posedge ref_clk_in);
    if (expq.size() > 0) n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
